// [adcc_pkg.sv]
// package of constants for the converter control block
package adcc_pkg;
  // control/status field layout
  localparam int CSR_CHAN_LSB   = 0;
  localparam int CSR_CHAN_W     = 4;
  localparam int CSR_ON_BIT     = 5;
  localparam int CSR_DONE_BIT   = 7;
  // result layout
  localparam int RES_W          = 10;
  localparam logic [7:0] HIGH_SAT  = 8'hff;
  localparam logic [1:0] LOW_SAT   = 2'h3;
  localparam logic [7:0] HIGH_ZERO = 8'h00;
  localparam logic [1:0] LOW_ZERO  = 2'h0;
  // reset values
  localparam logic [7:0] CSR_RST = 8'h00;
  // conversion time in core cycles
  localparam int CONV_CYCLES    = 14;
  localparam int CNT_W          = 5;
  // sequencer states
  typedef enum logic [2:0] {
    ADCC_IDLE   = 3'b001,
    ADCC_SAMPLE = 3'b010,
    ADCC_STORE  = 3'b100
  } adcc_state_t;
endpackage

// [adcc_chan_mux.sv]
// channel multiplexer with reference saturation
`timescale 1ns/1ps
module adcc_chan_mux
  import adcc_pkg::*;
#(
  parameter int NCHAN = 16
) (
  input  wire logic [NCHAN*RES_W-1:0] chan_code_in,   // raw codes per channel
  input  wire logic [NCHAN-1:0]       chan_over_in,   // input above high reference
  input  wire logic [NCHAN-1:0]       chan_under_in,  // input below low reference
  input  wire logic [CSR_CHAN_W-1:0]  sel_in,         // channel select
  output logic      [RES_W-1:0]       code_out        // saturated code
);
  wire [RES_W-1:0] picked = chan_code_in[sel_in*RES_W +: RES_W];
  wire             over   = chan_over_in[sel_in];
  wire             under  = chan_under_in[sel_in];
  // over wins: saturate all ones, under gives zero
  assign code_out = over  ? {HIGH_SAT, LOW_SAT} :   // [R1]
                    under ? {HIGH_ZERO, LOW_ZERO} : // [R2]
                    picked;
endmodule

// [adcc_top.sv]
// converter control: channel select, continuous conversion, result and flag
// ---------------------------------------------------------------
// Notes on behaviour
// R1 - input above high reference gives high ff and low 3
// R2 - input below low reference gives zero result
// R3 - four-bit select chooses converted channel
// R4 - converter_on starts continuous back-to-back conversions
// R5 - each completion sets done flag and stores result
// R6 - high byte read or control write clears done flag
// R7 - software reads low then high for ten bits
// R8 - software reads high only for eight bits
// R9 - results are overwritten by next completion, read before it
// R10 - clearing converter_on stops conversions, last result stays
// ---------------------------------------------------------------
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int NCHAN = 16,
  parameter int CONV  = CONV_CYCLES
) (
  input  wire logic                   core_clk_in,      // cpu clock
  input  wire logic                   rst_in,           // sync reset, high
  input  wire logic [NCHAN*RES_W-1:0] chan_code_in,     // analog codes per channel
  input  wire logic [NCHAN-1:0]       chan_over_in,     // above high_reference
  input  wire logic [NCHAN-1:0]       chan_under_in,    // below low_reference
  input  wire logic                   csr_wr_in,        // control/status write strobe
  input  wire logic [7:0]             csr_wdata_in,     // control/status write data
  input  wire logic                   high_rd_in,       // result_high_byte read strobe
  output logic      [7:0]             converter_control_status_out, // csr readback
  output logic      [7:0]             result_high_byte_out,         // upper 8 bits
  output logic      [7:0]             result_low_bits_out,          // low 2 bits
  output logic                        done_out          // completion flag
);
  // ---------------------------------------------------------------
  // control register and state
  // ---------------------------------------------------------------
  logic [CSR_CHAN_W-1:0] chan_sel;
  logic                  converter_on;
  logic                  done;
  logic [RES_W-1:0]      result;
  logic [CNT_W-1:0]      cnt;
  adcc_state_t           state;
  adcc_state_t           next_state;
  logic [RES_W-1:0]      code;

  adcc_chan_mux #(.NCHAN(NCHAN)) adcc_chan_mux_i (
    .chan_code_in  (chan_code_in),
    .chan_over_in  (chan_over_in),
    .chan_under_in (chan_under_in),
    .sel_in        (chan_sel),        // [R3]
    .code_out      (code)
  );

  wire conv_end = (state == ADCC_SAMPLE) && (cnt == CNT_W'(CONV - 1));
  wire finish   = (state == ADCC_STORE);
  wire clr_done = high_rd_in | csr_wr_in;

  // control register write
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      chan_sel     <= CSR_RST[CSR_CHAN_LSB +: CSR_CHAN_W];
      converter_on <= CSR_RST[CSR_ON_BIT];
    end else if (csr_wr_in) begin
      chan_sel     <= csr_wdata_in[CSR_CHAN_LSB +: CSR_CHAN_W]; // [R3]
      converter_on <= csr_wdata_in[CSR_ON_BIT];                 // [R4] [R10]
    end
  end

  // ---------------------------------------------------------------
  // sequencer: sample for CONV cycles, store, repeat while on
  // ---------------------------------------------------------------
  always_comb begin
    case (state)
      ADCC_IDLE:   next_state = converter_on ? ADCC_SAMPLE : ADCC_IDLE;  // [R4]
      ADCC_SAMPLE: next_state = !converter_on ? ADCC_IDLE :              // [R10]
                                conv_end ? ADCC_STORE : ADCC_SAMPLE;
      ADCC_STORE:  next_state = converter_on ? ADCC_SAMPLE : ADCC_IDLE;  // [R4]
      default:     next_state = ADCC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= ADCC_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= (state == ADCC_SAMPLE && !conv_end) ? cnt + CNT_W'(1) : '0;
    end
  end

  // result store (not held: next completion overwrites) and flag
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      result <= '0;
      done   <= 1'b0;
    end else begin
      if (conv_end && converter_on) result <= code; // [R5] [R9]
      if (finish) done <= 1'b1;                     // [R5] set wins
      else if (clr_done) done <= 1'b0;              // [R6]
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign converter_control_status_out = {done, 1'b0, converter_on, 1'b0, chan_sel};
  assign result_high_byte_out = result[RES_W-1 -: 8];   // [R7] [R8]
  assign result_low_bits_out  = {6'h00, result[1:0]};   // [R7]
  assign done_out             = done;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  done_sets_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    finish |=> done) else $error("done not set after store");
  done_clears_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R6]
    (clr_done && !finish && state != ADCC_STORE) |=> !done)
    else $error("done not cleared by access");
  off_stops_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
    (!converter_on && state == ADCC_IDLE) |=> $stable(result))
    else $error("result changed while off");
  repeat_conv_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
    (finish && converter_on && !csr_wr_in) |=> state == ADCC_SAMPLE)
    else $error("conversion not restarted");
  sat_high_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
    (conv_end && converter_on && chan_over_in[chan_sel]) |=> result == {HIGH_SAT, LOW_SAT})
    else $error("over range not saturated");
  zero_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
    (conv_end && converter_on && chan_under_in[chan_sel] && !chan_over_in[chan_sel])
    |=> result == {HIGH_ZERO, LOW_ZERO}) else $error("under range not zero");
  sel_store_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
    (conv_end && converter_on && !chan_over_in[chan_sel] && !chan_under_in[chan_sel])
    |=> result == $past(chan_code_in[chan_sel*RES_W +: RES_W]))
    else $error("wrong channel stored");
  conv_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    finish |-> $past(state, 1) == ADCC_SAMPLE) else $error("store without sample");

  // ---------------------------------------------------------------
  // sequencer checks
  // ---------------------------------------------------------------
  // the state register must always hold exactly one of the one-hot codes
  state_onehot_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
    $onehot(state)) else $error("sequencer state not one-hot");
  // an enabled idle converter starts sampling on the next edge
  start_conv_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
    (state == ADCC_IDLE && converter_on) |=> state == ADCC_SAMPLE)
    else $error("conversion not started");
  // the sample counter never runs past the last sample cycle
  cnt_bound_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    (state == ADCC_SAMPLE) |-> cnt < CNT_W'(CONV))
    else $error("sample counter out of range");
  // a store only follows a full-length sample phase
  sample_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    finish |-> $past(cnt) == CNT_W'(CONV - 1))
    else $error("sample phase too short");
  // the store state lasts one cycle only
  store_once_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    finish |=> !finish) else $error("store state repeated");
  // switching off in mid-sample parks the sequencer at once
  off_idle_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
    (state == ADCC_SAMPLE && !converter_on) |=> state == ADCC_IDLE)
    else $error("sampling went on while off");

  // ---------------------------------------------------------------
  // control register checks
  // ---------------------------------------------------------------
  // a write lands the channel field on the following edge
  chan_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
    csr_wr_in |=> chan_sel == $past(csr_wdata_in[CSR_CHAN_LSB +: CSR_CHAN_W]))
    else $error("channel field not written");
  // a write lands the enable bit on the following edge
  on_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R4]
    csr_wr_in |=> converter_on == $past(csr_wdata_in[CSR_ON_BIT]))
    else $error("enable bit not written");

  // ---------------------------------------------------------------
  // result and flag checks
  // ---------------------------------------------------------------
  // the result only moves at the end of an enabled conversion
  result_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R9]
    !(conv_end && converter_on) |=> $stable(result))
    else $error("result moved outside a store");
  // a raised flag stays up until an access clears it
  done_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
    (done && !clr_done) |=> done) else $error("done dropped without access");
  // with the converter off and no store pending, the flag cannot rise
  off_no_done_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
    (!converter_on && state != ADCC_STORE && !done) |=> !done)
    else $error("done rose while off");

  // ---------------------------------------------------------------
  // parked converter watch
  // ---------------------------------------------------------------
  // counts cycles idle with the converter off; saturates instead of wrapping
  logic [CNT_W-1:0] idle_cnt;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      idle_cnt <= '0;
    end else if (state == ADCC_IDLE && !converter_on) begin
      idle_cnt <= (idle_cnt == '1) ? idle_cnt : idle_cnt + CNT_W'(1);
    end else begin
      idle_cnt <= '0;
    end
  end

  // once parked, no conversion may end and nothing may be stored
  parked_quiet_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
    (idle_cnt != '0) |-> (!finish && !conv_end))
    else $error("activity while parked");
  // a parked converter keeps its last result on the high byte output
  parked_keep_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
    (idle_cnt != '0 && !converter_on) |=> $stable(result_high_byte_out))
    else $error("high byte changed while parked");
endmodule

// [adcc_ana_model.sv]
// analog input model: per-channel codes and reference flags
`timescale 1ns/1ps
module adcc_ana_model
  import adcc_pkg::*;
(
  input  wire logic [RES_W-1:0]    base_in,        // code of channel 0
  input  wire logic [15:0]         over_sel_in,    // channels above high_reference
  input  wire logic [15:0]         under_sel_in,   // channels below low_reference
  output logic      [16*RES_W-1:0] chan_code_out,  // codes per channel
  output logic      [15:0]         chan_over_out,  // over flags
  output logic      [15:0]         chan_under_out  // under flags
);
  // each channel gets a distinct code so a wrong select shows
  for (genvar k = 0; k < 16; k++) begin : g_ch
    assign chan_code_out[k*RES_W +: RES_W] = base_in + RES_W'(k * 37);
  end
  assign chan_over_out  = over_sel_in;
  assign chan_under_out = under_sel_in;
endmodule

// [adcc_top_tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_tb;
  import adcc_pkg::*;
  logic core_clk_in = 1'b0, rst_in = 1'b1, csr_wr_in = 1'b0, high_rd_in = 1'b0;
  logic [7:0] csr_wdata_in = 8'h00;
  logic [9:0] base = 10'h155;
  logic [15:0] over = 16'h0000, under = 16'h0000;
  logic [159:0] codes;
  logic [15:0] ov, un;
  logic [7:0] csr_o, hi_o, lo_o;
  logic done_o;
  int n_errors = 0, cmp_count = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  adcc_ana_model adcc_ana_model_i (.base_in(base), .over_sel_in(over), .under_sel_in(under),
    .chan_code_out(codes), .chan_over_out(ov), .chan_under_out(un));
  adcc_top adcc_top_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .chan_code_in(codes),
    .chan_over_in(ov), .chan_under_in(un), .csr_wr_in(csr_wr_in), .csr_wdata_in(csr_wdata_in),
    .high_rd_in(high_rd_in), .converter_control_status_out(csr_o),
    .result_high_byte_out(hi_o), .result_low_bits_out(lo_o), .done_out(done_o));
  task automatic step(int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic cmp(string nm, logic [9:0] exp, logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_csr(logic [7:0] d);
    csr_wdata_in = d;
    csr_wr_in = 1'b1;
    step(1);
    csr_wr_in = 1'b0;
    step(1);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 40 && done_o !== 1'b1; i++) step(1);
    if (i == 40) begin
      cmp("done wait", 10'h1, 10'h0);
      end_sim;
    end
  endtask
  // software sequence: low first when full, then high read clears the flag
  task automatic rd_res(logic [9:0] exp, bit full);
    if (full) cmp("low bits", {8'h00, exp[1:0]}, {2'b00, lo_o});
    high_rd_in = 1'b1;
    step(1);
    high_rd_in = 1'b0;
    cmp("high byte", {2'b00, exp[9:2]}, {2'b00, hi_o});
    cmp("done after read", 10'h0, {9'h0, done_o});
  endtask
  // restart on channel k and read one full result
  task automatic conv_chan(int k, logic [9:0] exp);
    wr_csr(8'h00);
    wr_csr(8'h20 | 8'(k));
    wait_done();
    rd_res(exp, 1'b1);
  endtask
  initial begin
    step(3);
    rst_in = 1'b0;
    cmp("csr at reset", 10'h0, {2'b00, csr_o});
    for (int k = 0; k < 16; k++) conv_chan(k, base + 10'(k * 37));
    over = 16'hffff;
    conv_chan(9, 10'h3ff);
    over = 16'h0000;
    under = 16'hffff;
    conv_chan(4, 10'h000);
    under = 16'h0000;
    wait_done();
    rd_res(base + 10'(4 * 37), 1'b0);
    wait_done();
    wr_csr(8'h24);
    cmp("done after write", 10'h0, {9'h0, done_o});
    cmp("csr readback", 10'h24, {2'b00, csr_o});
    base = 10'h2c3;
    wait_done();
    cmp("new high", {2'b00, 8'hd5}, {2'b00, hi_o});
    base = 10'h0a0;
    step(16);
    cmp("overwritten high", {2'b00, 8'h4d}, {2'b00, hi_o});
    wr_csr(8'h04);
    base = 10'h000;
    step(60);
    cmp("done when off", 10'h0, {9'h0, done_o});
    cmp("kept high", {2'b00, 8'h4d}, {2'b00, hi_o});
    end_sim;
  end
endmodule
